// ---- hw/lis_pkg.sv ----
// Package for the status-indicator selector block: register map,
// field layout, reset values, display codes and timing constants.
// Assumes a 200 MHz core clock and an AXI4-Lite register slave.
package lis_pkg;

    // Register map (byte addresses)
    localparam logic [7:0] CFG_OFFSET = 8'h14;
    localparam logic [7:0] STATUS_OFFSET = 8'h18;
    localparam logic [15:0] CFG_RESET = 16'h0422;

    // Configuration field positions
    localparam int FIRST_SEL_LSB = 12;
    localparam int SECOND_SEL_LSB = 8;
    localparam int THIRD_SEL_LSB = 4;
    localparam int DUR_LSB = 2;
    localparam int STRETCH_EN_BIT = 1;
    localparam int RESERVED_BIT = 0;
    localparam int SEL_W = 4;
    localparam int NUM_IND = 3;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Display codes
    localparam logic [3:0] SEL_SPEED = 4'h0;
    localparam logic [3:0] SEL_TX = 4'h1;
    localparam logic [3:0] SEL_RX = 4'h2;
    localparam logic [3:0] SEL_COL = 4'h3;
    localparam logic [3:0] SEL_LINK = 4'h4;
    localparam logic [3:0] SEL_DUPLEX = 4'h5;
    localparam logic [3:0] SEL_ACT = 4'h7;
    localparam logic [3:0] SEL_ON = 4'h8;
    localparam logic [3:0] SEL_OFF = 4'h9;
    localparam logic [3:0] SEL_FAST = 4'ha;
    localparam logic [3:0] SEL_SLOW = 4'hb;
    localparam logic [3:0] SEL_LINK_RX = 4'hc;
    localparam logic [3:0] SEL_LINK_ACT = 4'hd;
    localparam logic [3:0] SEL_DUP_COL = 4'he;

    // Stretch duration codes
    localparam logic [1:0] DUR_30 = 2'h0;
    localparam logic [1:0] DUR_60 = 2'h1;
    localparam logic [1:0] DUR_100 = 2'h2;

    // Timing
    localparam longint CLK_HZ = 200000000;
    localparam longint STRETCH_30_MS = 30;
    localparam longint STRETCH_60_MS = 60;
    localparam longint STRETCH_100_MS = 100;
    localparam longint FAST_HALF_MS = 50;
    localparam longint SLOW_HALF_MS = 250;
    localparam longint MS_CYCLES = CLK_HZ / 1000;
    localparam int TIMER_W = 32;

    // Status inputs of the transceiver
    typedef struct packed {
        logic speed;
        logic tx;
        logic rx;
        logic col;
        logic link;
        logic duplex;
    } lis_status_t;

    // Configuration register fields
    typedef struct packed {
        logic [3:0] first_indicator_select;
        logic [3:0] second_indicator_select;
        logic [3:0] third_indicator_select;
        logic [1:0] stretch_duration;
        logic stretch_en;
        logic reserved;
    } lis_cfg_t;

endpackage

// ---- hw/lis_channel.sv ----
// One indicator channel: picks a display source from its selector,
// stretches events and toggles on secondary events in combined modes.
// Assumes shared blink phases and a stretch length from the top.
`timescale 1ns/1ps
module lis_channel
    import lis_pkg::*;
#(
    parameter int TW = TIMER_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] sel,
    input wire logic stretch_en,
    input wire logic [TW-1:0] stretch_len,
    input wire logic fast_phase,
    input wire logic slow_phase,
    input wire lis_status_t st,
    output logic led
);

    typedef struct packed {
        logic [TW-1:0] timer;
        logic prev_ev;
        logic toggle;
        logic led;
    } lis_ch_state_t;

    lis_ch_state_t cur;
    lis_ch_state_t next_st;
    logic ev;
    logic combined;
    logic stretched;
    logic ev_rise;

    always_comb begin
        combined = (sel == SEL_LINK_RX) || (sel == SEL_LINK_ACT)
                || (sel == SEL_DUP_COL);
        case (sel)
            SEL_TX: ev = st.tx;
            SEL_RX, SEL_LINK_RX: ev = st.rx;
            SEL_COL, SEL_DUP_COL: ev = st.col;
            SEL_ACT, SEL_LINK_ACT: ev = st.rx | st.tx;
            default: ev = 1'b0;
        endcase
        ev_rise = ev & ~cur.prev_ev;
        next_st = cur;
        next_st.prev_ev = ev;
        // Combined modes stretch whatever the global enable says
        if (ev) begin
            next_st.timer = stretch_len;
        end else if (cur.timer != '0) begin
            next_st.timer = cur.timer - TW'(1);
        end
        stretched = ev || (cur.timer != '0);
        // Each new secondary event flips the blink phase; the phase
        // returns to zero when the stretch ends so the next event blinks
        if (!combined || !stretched) begin
            next_st.toggle = 1'b0;
        end else if (ev_rise) begin
            next_st.toggle = ~cur.toggle;
        end
        case (sel)
            SEL_SPEED: next_st.led = st.speed;
            SEL_TX, SEL_RX, SEL_COL, SEL_ACT:
                next_st.led = stretch_en ? stretched : ev;
            SEL_LINK: next_st.led = st.link;
            SEL_DUPLEX: next_st.led = st.duplex;
            SEL_ON: next_st.led = 1'b1;
            SEL_OFF: next_st.led = 1'b0;
            SEL_FAST: next_st.led = fast_phase;
            SEL_SLOW: next_st.led = slow_phase;
            SEL_LINK_RX:
                next_st.led = stretched ? (st.link ^ cur.toggle) : st.link;
            SEL_LINK_ACT:
                next_st.led = stretched ? (st.link ^ cur.toggle) : st.link;
            SEL_DUP_COL:
                next_st.led = stretched ? (st.duplex ^ cur.toggle)
                                        : st.duplex;
            // Unassigned codes leave the indicator dark
            default: next_st.led = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cur <= '0;
        end else begin
            cur <= next_st;
        end
    end

    assign led = cur.led;

endmodule

// ---- hw/lis_top.sv ----
// Top of the status-indicator selector: AXI4-Lite slave with the
// configuration register, shared timers and three indicator channels.
// Assumes status inputs synchronous to REF_CLK_IN, sync reset.
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps

// Contract
// - Codes 0-5 and 7 show speed, tx, rx, collision, link, duplex, activity.
// - Codes 8-11 force on, off, fast blink, slow blink.
// - Code 12 shows link primary with receive secondary.
// - Code 13 shows link primary with activity secondary.
// - Code 14 shows duplex primary with collision secondary.
// - Link modes: solid while link up, each secondary event blinks.
// - Link-activity mode blinks on activity even with link down.
// - Duplex-collision mode: solid when full duplex, collisions blink.
// - Combined modes always stretch, ignoring the global enable.
// - Duration field selects 30, 60 or 100 ms; code 3 reserved.
// - Global stretch enable bit resets to 1, gates stretching.
// - Reset selectors: first speed, second link, third receive.
// - Event displays stretch; level displays and tests follow directly.
// - Reserved bit 0 written zero; its read value is meaningless.
module lis_top
    import lis_pkg::*;
#(
    parameter int TW = TIMER_W,
    parameter longint MS_CYC = MS_CYCLES,
    parameter longint STRETCH_30 = STRETCH_30_MS * MS_CYC,
    parameter longint STRETCH_60 = STRETCH_60_MS * MS_CYC,
    parameter longint STRETCH_100 = STRETCH_100_MS * MS_CYC,
    parameter longint FAST_HALF = FAST_HALF_MS * MS_CYC,
    parameter longint SLOW_HALF = SLOW_HALF_MS * MS_CYC
) (
    // Clock and reset
    input wire logic REF_CLK_IN,
    input wire logic RST_IN,
    // AXI4-Lite write address and data
    input wire logic [7:0] S_AXI_AWADDR_IN,
    input wire logic S_AXI_AWVALID_IN,
    output logic S_AXI_AWREADY_OUT,
    input wire logic [31:0] S_AXI_WDATA_IN,
    input wire logic [3:0] S_AXI_WSTRB_IN,
    input wire logic S_AXI_WVALID_IN,
    output logic S_AXI_WREADY_OUT,
    // AXI4-Lite write response
    output logic [1:0] S_AXI_BRESP_OUT,
    output logic S_AXI_BVALID_OUT,
    input wire logic S_AXI_BREADY_IN,
    // AXI4-Lite read
    input wire logic [7:0] S_AXI_ARADDR_IN,
    input wire logic S_AXI_ARVALID_IN,
    output logic S_AXI_ARREADY_OUT,
    output logic [31:0] S_AXI_RDATA_OUT,
    output logic [1:0] S_AXI_RRESP_OUT,
    output logic S_AXI_RVALID_OUT,
    input wire logic S_AXI_RREADY_IN,
    // Transceiver status
    input wire logic SPEED_IN,
    input wire logic TX_IN,
    input wire logic RX_IN,
    input wire logic COL_IN,
    input wire logic LINK_IN,
    input wire logic DUPLEX_IN,
    // Indicator drives, high lights the LED
    output logic [NUM_IND-1:0] LED_OUT
);

    typedef struct packed {
        lis_cfg_t cfg;
        logic aw_got;
        logic [7:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [TW-1:0] fast_cnt;
        logic [TW-1:0] slow_cnt;
        logic fast_phase;
        logic slow_phase;
        logic aw_rdy;
        logic w_rdy;
        logic ar_rdy;
    } lis_top_state_t;

    lis_top_state_t cur;
    lis_top_state_t next_st;
    lis_status_t st;
    logic [TW-1:0] stretch_len;
    logic [NUM_IND-1:0] led;
    logic [NUM_IND*SEL_W-1:0] sels;
    logic [15:0] wr_val;
    logic [15:0] cfg_bits;

    assign st = '{speed: SPEED_IN, tx: TX_IN, rx: RX_IN, col: COL_IN,
                  link: LINK_IN, duplex: DUPLEX_IN};
    assign sels = {cur.cfg.first_indicator_select,
                   cur.cfg.second_indicator_select,
                   cur.cfg.third_indicator_select};

    always_comb begin
        case (cur.cfg.stretch_duration)
            DUR_30: stretch_len = TW'(STRETCH_30);
            DUR_60: stretch_len = TW'(STRETCH_60);
            DUR_100: stretch_len = TW'(STRETCH_100);
            // Reserved code falls back to the longest stretch
            default: stretch_len = TW'(STRETCH_100);
        endcase
    end

    always_comb begin
        next_st = cur;
        cfg_bits = cur.cfg;
        wr_val = cfg_bits;
        // Blink generators count the core clock
        if (cur.fast_cnt >= TW'(FAST_HALF - 1)) begin
            next_st.fast_cnt = '0;
            next_st.fast_phase = ~cur.fast_phase;
        end else begin
            next_st.fast_cnt = cur.fast_cnt + TW'(1);
        end
        if (cur.slow_cnt >= TW'(SLOW_HALF - 1)) begin
            next_st.slow_cnt = '0;
            next_st.slow_phase = ~cur.slow_phase;
        end else begin
            next_st.slow_cnt = cur.slow_cnt + TW'(1);
        end
        // Write channel: address and data taken in either order
        if (S_AXI_AWVALID_IN && !cur.aw_got && !cur.bvalid) begin
            next_st.aw_got = 1'b1;
            next_st.awaddr = S_AXI_AWADDR_IN;
        end
        if (S_AXI_WVALID_IN && !cur.w_got && !cur.bvalid) begin
            next_st.w_got = 1'b1;
            next_st.wdata = S_AXI_WDATA_IN;
            next_st.wstrb = S_AXI_WSTRB_IN;
        end
        if (cur.aw_got && cur.w_got && !cur.bvalid) begin
            next_st.aw_got = 1'b0;
            next_st.w_got = 1'b0;
            next_st.bvalid = 1'b1;
            if (cur.awaddr[7:2] == CFG_OFFSET[7:2]) begin
                next_st.bresp = RESP_OKAY;
                if (cur.wstrb[0]) begin
                    wr_val[7:0] = cur.wdata[7:0];
                end
                if (cur.wstrb[1]) begin
                    wr_val[15:8] = cur.wdata[15:8];
                end
                // Reserved bit is stored as zero whatever is written
                wr_val[RESERVED_BIT] = 1'b0;
                next_st.cfg = wr_val;
            end else if (cur.awaddr[7:2] == STATUS_OFFSET[7:2]) begin
                next_st.bresp = RESP_OKAY;
            end else begin
                next_st.bresp = RESP_SLVERR;
            end
        end else if (cur.bvalid && S_AXI_BREADY_IN) begin
            next_st.bvalid = 1'b0;
        end
        // Read channel
        if (S_AXI_ARVALID_IN && !cur.rvalid) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = RESP_OKAY;
            if (S_AXI_ARADDR_IN[7:2] == CFG_OFFSET[7:2]) begin
                next_st.rdata = {16'h0000, cfg_bits};
            end else if (S_AXI_ARADDR_IN[7:2] == STATUS_OFFSET[7:2]) begin
                next_st.rdata = {16'h0000, 4'h0, led, 1'b0,
                                 cur.slow_phase, cur.fast_phase, st};
            end else begin
                next_st.rdata = 32'h0000_0000;
                next_st.rresp = RESP_SLVERR;
            end
        end else if (cur.rvalid && S_AXI_RREADY_IN) begin
            next_st.rvalid = 1'b0;
        end
        // Readies are registered so every bus output leaves a flop
        next_st.aw_rdy = !next_st.aw_got && !next_st.bvalid;
        next_st.w_rdy = !next_st.w_got && !next_st.bvalid;
        next_st.ar_rdy = !next_st.rvalid;
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            cur <= '0;
            cur.cfg <= CFG_RESET;
            cur.aw_rdy <= 1'b1;
            cur.w_rdy <= 1'b1;
            cur.ar_rdy <= 1'b1;
        end else begin
            cur <= next_st;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_IND; gi++) begin : g_ch
            lis_channel #(
                .TW(TW)
            ) u_ch (
                .clk(REF_CLK_IN),
                .rst(RST_IN),
                .sel(sels[(NUM_IND-gi)*SEL_W-1 -: SEL_W]),
                .stretch_en(cur.cfg.stretch_en),
                .stretch_len(stretch_len),
                .fast_phase(cur.fast_phase),
                .slow_phase(cur.slow_phase),
                .st(st),
                .led(led[gi])
            );
        end
    endgenerate

    assign LED_OUT = led;
    assign S_AXI_AWREADY_OUT = cur.aw_rdy;
    assign S_AXI_WREADY_OUT = cur.w_rdy;
    assign S_AXI_BVALID_OUT = cur.bvalid;
    assign S_AXI_BRESP_OUT = cur.bresp;
    assign S_AXI_ARREADY_OUT = cur.ar_rdy;
    assign S_AXI_RVALID_OUT = cur.rvalid;
    assign S_AXI_RDATA_OUT = cur.rdata;
    assign S_AXI_RRESP_OUT = cur.rresp;

endmodule

// ---- tb/lis_top_monitor.sv ----
// Checker for the indicator selector top: bus handshakes and reset state.
// Assumes it is bound to lis_top and sees only that module's ports.
`timescale 1ns/1ps
module lis_top_monitor
    import lis_pkg::*;
(
    // Clock and reset
    input wire logic REF_CLK_IN,
    input wire logic RST_IN,
    // Write channels
    input wire logic S_AXI_AWVALID_IN,
    input wire logic S_AXI_AWREADY_OUT,
    input wire logic S_AXI_WVALID_IN,
    input wire logic S_AXI_WREADY_OUT,
    input wire logic [1:0] S_AXI_BRESP_OUT,
    input wire logic S_AXI_BVALID_OUT,
    input wire logic S_AXI_BREADY_IN,
    // Read channels
    input wire logic S_AXI_ARVALID_IN,
    input wire logic S_AXI_ARREADY_OUT,
    input wire logic [31:0] S_AXI_RDATA_OUT,
    input wire logic S_AXI_RVALID_OUT,
    input wire logic S_AXI_RREADY_IN,
    // Indicators
    input wire logic [NUM_IND-1:0] LED_OUT
);
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (RST_IN);

    a_reset_state: assert property ($fell(RST_IN) |-> LED_OUT == 3'h0
        && !S_AXI_BVALID_OUT && !S_AXI_RVALID_OUT && S_AXI_ARREADY_OUT)
        else $error("outputs not cleared by reset");
    a_bresp_hold: assert property (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN
        |=> S_AXI_BVALID_OUT && $stable(S_AXI_BRESP_OUT))
        else $error("write response dropped early");
    a_rdata_hold: assert property (S_AXI_RVALID_OUT && !S_AXI_RREADY_IN
        |=> S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT))
        else $error("read data dropped early");
    a_bresp_done: assert property (S_AXI_BVALID_OUT && S_AXI_BREADY_IN
        |=> !S_AXI_BVALID_OUT) else $error("write response repeated");
    a_rdata_done: assert property (S_AXI_RVALID_OUT && S_AXI_RREADY_IN
        |=> !S_AXI_RVALID_OUT) else $error("read data repeated");
    a_read_busy: assert property (S_AXI_RVALID_OUT |-> !S_AXI_ARREADY_OUT)
        else $error("read address taken while busy");
    a_write_busy: assert property (S_AXI_BVALID_OUT
        |-> !S_AXI_AWREADY_OUT && !S_AXI_WREADY_OUT)
        else $error("write taken while response pending");
    a_write_answer: assert property (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT
        && S_AXI_WVALID_IN && S_AXI_WREADY_OUT
        |=> !S_AXI_AWREADY_OUT ##1 S_AXI_BVALID_OUT)
        else $error("write response late");
    a_read_answer: assert property (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT
        |=> S_AXI_RVALID_OUT) else $error("read data late");
endmodule

bind lis_top lis_top_monitor mon (.REF_CLK_IN, .RST_IN, .S_AXI_AWVALID_IN,
    .S_AXI_AWREADY_OUT, .S_AXI_WVALID_IN, .S_AXI_WREADY_OUT,
    .S_AXI_BRESP_OUT, .S_AXI_BVALID_OUT, .S_AXI_BREADY_IN,
    .S_AXI_ARVALID_IN, .S_AXI_ARREADY_OUT, .S_AXI_RDATA_OUT,
    .S_AXI_RVALID_OUT, .S_AXI_RREADY_IN, .LED_OUT);

// ---- tb/lis_led_model.sv ----
// LED model: counts toggles of the first indicator and the cycles it
// differs from its level at the last clear. Assumes one shared clock.
`timescale 1ns/1ps
module lis_led_model (
    input wire logic clk,
    input wire logic clr,
    input wire logic [2:0] led,
    output int tog,
    output int dev
);
    logic ref_lvl;
    logic prev;

    always @(posedge clk) begin
        if (clr) begin
            tog <= 0;
            dev <= 0;
            ref_lvl <= led[0];
        end else begin
            tog <= tog + int'(led[0] != prev);
            dev <= dev + int'(led[0] != ref_lvl);
        end
        prev <= led[0];
    end
endmodule

// ---- tb/lis_top_test.sv ----
// Bench for the indicator selector: AXI4-Lite tasks, random status,
// stretch and blink checks. Short counts are set at the instance.
`timescale 1ns/1ps
module lis_top_test;
    import lis_pkg::*;
    logic clk = 0, rst = 1, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
    logic awr, wr_rdy, bv, arr, rv, clr = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [3:0] wstrb = 4'hf;
    logic [1:0] bresp, rresp;
    lis_status_t st = 0;
    logic [2:0] led;
    int tog, dev, err_count = 0, cmp_count = 0, seed = 79281;

    always #2.5 clk = ~clk;

    lis_top #(.STRETCH_30(20), .STRETCH_60(40), .STRETCH_100(60),
        .FAST_HALF(8), .SLOW_HALF(32)) dut (.REF_CLK_IN(clk),
        .RST_IN(rst), .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awv),
        .S_AXI_AWREADY_OUT(awr), .S_AXI_WDATA_IN(wdata),
        .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wv),
        .S_AXI_WREADY_OUT(wr_rdy), .S_AXI_BRESP_OUT(bresp),
        .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(bready),
        .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arv),
        .S_AXI_ARREADY_OUT(arr), .S_AXI_RDATA_OUT(rdata),
        .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rv),
        .S_AXI_RREADY_IN(rready), .SPEED_IN(st.speed), .TX_IN(st.tx),
        .RX_IN(st.rx), .COL_IN(st.col), .LINK_IN(st.link),
        .DUPLEX_IN(st.duplex), .LED_OUT(led));

    lis_led_model leds (.clk(clk), .clr(clr), .led(led), .tog(tog),
        .dev(dev));

    task results;
        $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int i;
        awaddr <= a;
        wdata <= d;
        awv <= 1;
        wv <= 1;
        bready <= 1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (awv && awr) awv <= 0;
            if (wv && wr_rdy) wv <= 0;
            if (bv) begin
                bready <= 0;
                r = bresp;
                break;
            end
        end
        if (i == 50) begin
            err_count++;
            results;
        end
        @(posedge clk);
    endtask

    task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int i;
        araddr <= a;
        arv <= 1;
        rready <= 1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (arv && arr) arv <= 0;
            if (rv) begin
                rready <= 0;
                d = rdata;
                r = rresp;
                break;
            end
        end
        if (i == 50) begin
            err_count++;
            results;
        end
        @(posedge clk);
    endtask

    task cfg(input logic [3:0] c, input logic [1:0] du, input logic e);
        logic [1:0] r;
        wr(CFG_OFFSET, {16'h0, c, c, c, du, e, 1'b0}, r);
        chk(r, RESP_OKAY);
    endtask

    function logic exp_src(logic [3:0] c, lis_status_t s);
        case (c)
            SEL_SPEED: return s.speed;
            SEL_TX: return s.tx;
            SEL_RX: return s.rx;
            SEL_COL: return s.col;
            SEL_LINK: return s.link;
            SEL_DUPLEX: return s.duplex;
            SEL_ACT: return s.tx | s.rx;
            SEL_ON: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // One event pulse; the LED must leave its idle level for lo..lo+3
    task sc(input logic [3:0] c, input logic e, input logic [1:0] du,
        input logic [5:0] b, input logic [5:0] ev, input logic p,
        input int lo);
        // Idle status first, so no stale event loads the timer
        st <= b;
        cfg(c, du, e);
        repeat (4) @(posedge clk);
        chk(led, {3{p}});
        clr <= 1;
        @(posedge clk) clr <= 0;
        st <= b | ev;
        @(posedge clk) st <= b;
        repeat (100) @(posedge clk);
        chk(dev >= lo && dev <= lo + 3, 1);
        $display("Test stretch code %h done", c);
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        results;
    end

    initial begin
        logic [31:0] d;
        logic [1:0] r;
        int k;
        logic [3:0] codes[9] = '{SEL_SPEED, SEL_TX, SEL_RX, SEL_COL,
            SEL_LINK, SEL_DUPLEX, SEL_ACT, SEL_ON, SEL_OFF};
        repeat (10) @(posedge clk);
        rst <= 0;
        st <= 6'($random(seed)) & 6'h37;
        rd(CFG_OFFSET, d, r);
        chk(d, {16'h0, CFG_RESET});
        chk(led, {1'b0, st.link, st.speed});
        wr(CFG_OFFSET, 32'h5a96, r);
        rd(CFG_OFFSET, d, r);
        chk(d & 32'hfffe, 32'h5a96);
        // Low byte lane only: the upper byte must keep its value
        wstrb <= 4'h1;
        wr(CFG_OFFSET, 32'h1234, r);
        wstrb <= 4'hf;
        rd(CFG_OFFSET, d, r);
        chk(d & 32'hfffe, 32'h5a34);
        wr(8'h40, 32'h1, r);
        chk(r, RESP_SLVERR);
        rd(8'h40, d, r);
        chk(r, RESP_SLVERR);
        $display("Test register done");
        // Stretching off, so event displays follow their level too
        foreach (codes[k]) begin
            cfg(codes[k], DUR_30, 0);
            repeat (4) begin
                st <= 6'($random(seed));
                repeat (4) @(posedge clk);
                chk(led, {3{exp_src(codes[k], st)}});
            end
            $display("Test code %h done", codes[k]);
        end
        // All indicators are off here, so the status word is the inputs
        rd(STATUS_OFFSET, d, r);
        chk(d & 32'hffff_ff3f, {26'h0, st});
        chk(r, RESP_OKAY);
        wr(STATUS_OFFSET, 32'h0, r);
        chk(r, RESP_OKAY);
        $display("Test status done");
        for (k = 0; k < 2; k++) begin
            cfg(k ? SEL_SLOW : SEL_FAST, DUR_30, 1);
            clr <= 1;
            @(posedge clk) clr <= 0;
            // 64 counted intervals hold a whole number of half periods
            repeat (65) @(posedge clk);
            chk(tog, k ? 2 : 8);
            $display("Test blink %0d done", k);
        end
        sc(SEL_TX, 1, DUR_30, 0, 6'h10, 0, 20);
        sc(SEL_RX, 1, DUR_60, 0, 6'h08, 0, 40);
        sc(SEL_COL, 1, DUR_100, 0, 6'h04, 0, 60);
        sc(SEL_ACT, 0, DUR_100, 0, 6'h08, 0, 1);
        sc(SEL_LINK_RX, 0, DUR_30, 6'h02, 6'h08, 1, 20);
        sc(SEL_LINK_ACT, 0, DUR_60, 6'h02, 6'h10, 1, 40);
        sc(SEL_LINK_ACT, 1, DUR_30, 0, 6'h08, 0, 20);
        sc(SEL_DUP_COL, 0, DUR_30, 6'h01, 6'h04, 1, 20);
        results;
    end
endmodule
